//--- dv/nand_dev_model.sv
// behavioural nand flash device for the host controller bench
`timescale 1ns/1ps
module nand_dev_model #(
	parameter int BUSY_CYC = 20
) (
	input  wire logic       clk_i,
	input  wire logic       ce_n_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic [7:0] io_i,
	output logic      [7:0] io_o,
	output logic            rb_o
);
	logic [7:0]  cmd_q[$];
	logic [7:0]  adr_q[$];
	logic [7:0]  a[5];
	logic [7:0]  last = 8'h00;
	logic [18:0] drow = 19'h00000;
	logic [18:0] orow = 19'h00000;
	logic [11:0] col = 12'h000;
	logic        we_d = 1'b1;
	logic        re_d = 1'b1;
	logic        stat = 1'b0;
	logic        arr = 1'b1;
	logic        rnd = 1'b0;
	logic [18:0] row;
	int          na = 0;
	int          bsy = 0;
	assign rb_o = (bsy == 0);
	assign row = {a[4][2:0], a[3], a[2]};
	assign io_o = (!ce_n_i && !re_n_i) ? (stat ? {1'b0, rb_o, arr, 5'h00}
		: orow[7:0] + col[7:0]) : ~last;
	always @(posedge clk_i) begin
		we_d <= we_n_i;
		re_d <= re_n_i;
		if (bsy > 0) bsy <= bsy - 1;
		if (!ce_n_i && !re_n_i) last <= io_o;
		if (re_n_i && !re_d && !stat) col <= col + 12'h001;
		if (!ce_n_i && we_n_i && !we_d && ale_i) begin
			adr_q.push_back(io_i);
			a[na % 5] <= io_i;
			na <= na + 1;
		end
		if (!ce_n_i && we_n_i && !we_d && cle_i) begin
			cmd_q.push_back(io_i);
			na <= 0;
			case (io_i)
				8'h00: begin
					stat <= 1'b0;
					rnd <= 1'b1;
				end
				8'h05, 8'h06: stat <= 1'b0;
				8'he0: col <= {a[1][3:0], a[0]};
				8'h70: stat <= 1'b1;
				8'h30: begin
					drow <= row;
					orow <= row;
					col <= {a[1][3:0], a[0]};
					arr <= 1'b1;
					rnd <= 1'b0;
					bsy <= BUSY_CYC;
				end
				8'h31: begin
					orow <= drow;
					drow <= rnd ? row : drow + 19'h00001;
					col <= 12'h000;
					arr <= 1'b0;
					rnd <= 1'b0;
					bsy <= BUSY_CYC;
				end
				8'h3f: begin
					orow <= drow;
					col <= 12'h000;
					arr <= 1'b1;
					bsy <= BUSY_CYC;
				end
				8'h35, 8'h10, 8'hd0: bsy <= BUSY_CYC;
				default: ;
			endcase
		end
	end
endmodule

//--- dv/nand_host_ctrl_sva.sv
// assertions on the nand host controller ports
`timescale 1ns/1ps
module nand_host_ctrl_sva (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       op_valid_i,
	input wire logic       op_ready_o,
	input wire logic       done_o,
	input wire logic       rd_valid_o,
	input wire logic       rd_ready_i,
	input wire logic       ce_n_o,
	input wire logic       cle_o,
	input wire logic       ale_o,
	input wire logic       we_n_o,
	input wire logic       read_strobe_low_o,
	input wire logic [7:0] io_o,
	input wire logic       io_oe_o,
	input wire logic       ready_busy_output_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_latch_excl: assert property (!(cle_o && ale_o))
		else $error("cle and ale high together");
	a_write_drive: assert property (!we_n_o |-> io_oe_o && !ce_n_o)
		else $error("write strobe low without bus drive");
	a_latch_hold: assert property (!we_n_o |=> $stable(io_o) && $stable(cle_o) && $stable(ale_o))
		else $error("bus changed at write rising edge");
	a_write_pulse: assert property ($fell(we_n_o) |=> $rose(we_n_o))
		else $error("write strobe not one cycle");
	a_strobe_ready: assert property (!read_strobe_low_o |-> ready_busy_output_i)
		else $error("read strobe while device busy");
	a_strobe_bus: assert property (!read_strobe_low_o |-> !ce_n_o && !io_oe_o)
		else $error("read strobe with bus driven");
	a_strobe_pulse: assert property ($fell(read_strobe_low_o) |=> read_strobe_low_o)
		else $error("read strobe not one cycle");
	a_take_busy: assert property (op_valid_i && op_ready_o |=> !op_ready_o)
		else $error("request taken but still idle");
	a_done_pulse: assert property (done_o |-> op_ready_o ##1 !done_o)
		else $error("done not a pulse followed by idle");
	a_buf_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o)
		else $error("read word dropped during stall");
	c_stall: cover property (rd_valid_o && !rd_ready_i);
	c_busy: cover property ($fell(ready_busy_output_i));
	c_done: cover property (done_o);
endmodule
bind nand_host_ctrl nand_host_ctrl_sva chk_u (.clk_i, .rst_n_i, .op_valid_i, .op_ready_o, .done_o,
	.rd_valid_o, .rd_ready_i, .ce_n_o, .cle_o, .ale_o, .we_n_o, .read_strobe_low_o, .io_o,
	.io_oe_o, .ready_busy_output_i);

//--- dv/nand_host_ctrl_tb.sv
// testbench for the nand host controller
`timescale 1ns/1ps
module nand_host_ctrl_tb;
	import nand_host_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        op_valid_i = 1'b0;
	logic [3:0]  op_i = 4'h0;
	logic [11:0] col_i = 12'h000;
	logic [18:0] row_i = 19'h00000;
	logic [18:0] row2_i = 19'h00000;
	logic [15:0] count_i = 16'h0000;
	logic        rd_ready_i = 1'b1;
	logic        op_ready_o, done_o, rd_valid_o, ce_n_o, cle_o, ale_o, we_n_o, re_n, io_oe_o, rb;
	logic [7:0]  rd_data_o, io_o, dev_io, bus;
	logic [7:0]  got[$];
	int          fail_count = 0;
	int          compares = 0;
	assign bus = io_oe_o ? io_o : dev_io;
	always #20 clk_i = ~clk_i;
	nand_host_ctrl dut_u (.clk_i, .rst_n_i, .op_valid_i, .op_i, .col_i, .row_i, .row2_i,
		.count_i, .op_ready_o, .done_o, .rd_data_o, .rd_valid_o, .rd_ready_i, .ce_n_o, .cle_o,
		.ale_o, .we_n_o, .read_strobe_low_o(re_n), .io_o, .io_oe_o, .io_i(bus),
		.ready_busy_output_i(rb));
	nand_dev_model dev_u (.clk_i, .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o),
		.we_n_i(we_n_o), .re_n_i(re_n), .io_i(bus), .io_o(dev_io), .rb_o(rb));
	task automatic end_sim;
		if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chkq(input string what, input logic [7:0] q[$], input logic [7:0] e[$]);
		chk(what, e.size(), q.size());
		foreach (e[i]) if (i < q.size()) chk(what, e[i], q[i]);
	endtask
	task automatic chkd(input logic [18:0] r, input logic [11:0] c0, input int n);
		logic [11:0] c;
		chk("read count", n, got.size());
		foreach (got[i]) begin
			c = c0 + 12'(i);
			chk("read byte", r[7:0] + c[7:0], got[i]);
		end
	endtask
	task automatic run(input logic [3:0] op, input logic [11:0] c, input logic [18:0] r,
		input logic [18:0] r2, input int n, input bit stall);
		int k;
		bit dn;
		bit tk;
		dn = 1'b0;
		got.delete();
		dev_u.cmd_q.delete();
		dev_u.adr_q.delete();
		op_i = op;
		col_i = c;
		row_i = r;
		row2_i = r2;
		count_i = 16'(n);
		op_valid_i = 1'b1;
		for (k = 0; k < 3000 && !(dn && got.size() == n); k++) begin
			@(negedge clk_i);
			if (rd_valid_o === 1'b1 && rd_ready_i) got.push_back(rd_data_o);
			if (done_o === 1'b1 && !op_valid_i) dn = 1'b1;
			tk = op_valid_i && op_ready_o === 1'b1;
			@(posedge clk_i);
			#2;
			if (tk) op_valid_i = 1'b0;
			rd_ready_i = !stall || (k % 4 == 0);
		end
		if (k >= 3000) begin
			fail_count++;
			$display("CHECK FAILED completion expected done seen none");
			end_sim();
		end
	endtask
	task automatic t_page_read;
		run(OP_PAGE_READ, 12'h9a5, 19'h52345, 19'h0, 4, 1'b1);
		chkq("page cmds", dev_u.cmd_q, '{8'h00, 8'h30});
		chkq("page addr", dev_u.adr_q, '{8'ha5, 8'h09, 8'h45, 8'h23, 8'h05});
		chkd(19'h52345, 12'h9a5, 4);
	endtask
	task automatic t_cache;
		run(OP_CACHE_SEQ, 12'h0, 19'h0, 19'h0, 2, 1'b0);
		chkq("seq cmds", dev_u.cmd_q, '{8'h31});
		chkd(19'h52345, 12'h000, 2);
		run(OP_STATUS, 12'h0, 19'h0, 19'h0, 1, 1'b0);
		chkd(19'h00040, 12'h000, 1);
		run(OP_CACHE_RAND, 12'h777, 19'h01234, 19'h0, 2, 1'b0);
		chkq("rand cmds", dev_u.cmd_q, '{8'h00, 8'h31});
		chkq("rand addr", dev_u.adr_q, '{8'h00, 8'h00, 8'h34, 8'h12, 8'h00});
		chkd(19'h52346, 12'h000, 2);
		run(OP_CACHE_LAST, 12'h0, 19'h0, 19'h0, 2, 1'b0);
		chkq("last cmds", dev_u.cmd_q, '{8'h3f});
		chkd(19'h01234, 12'h000, 2);
		run(OP_STATUS, 12'h0, 19'h0, 19'h0, 1, 1'b0);
		chkd(19'h00060, 12'h000, 1);
	endtask
	task automatic t_col;
		run(OP_READ_DATA, 12'h0, 19'h0, 19'h0, 0, 1'b0);
		chkq("reread cmd", dev_u.cmd_q, '{8'h00});
		run(OP_COL_CHANGE, 12'hbc4, 19'h0, 19'h0, 3, 1'b1);
		chkq("col cmds", dev_u.cmd_q, '{8'h05, 8'he0});
		chkq("col addr", dev_u.adr_q, '{8'hc4, 8'h0b});
		chkd(19'h01234, 12'hbc4, 3);
	endtask
	task automatic t_multi;
		run(OP_TP_READ, 12'h0, 19'h00011, 19'h00022, 0, 1'b0);
		chkq("tp read", dev_u.cmd_q, '{8'h00, 8'h00, 8'h30});
		chk("tp addr", 8'h22, dev_u.adr_q[7]);
		run(OP_TP_CPB_READ, 12'h0, 19'h00011, 19'h00022, 0, 1'b0);
		chkq("tp cpb read", dev_u.cmd_q, '{8'h00, 8'h00, 8'h35});
		run(OP_PLANE_SELECT, 12'h0, 19'h00011, 19'h0, 0, 1'b0);
		chkq("plane sel", dev_u.cmd_q, '{8'h06, 8'he0});
		run(OP_TP_PROG, 12'h0, 19'h00011, 19'h00022, 0, 1'b0);
		chkq("tp prog", dev_u.cmd_q, '{8'h80, 8'h11, 8'h81, 8'h10});
		run(OP_TP_CPB_PROG, 12'h0, 19'h00011, 19'h00022, 0, 1'b0);
		chkq("tp cpb prog", dev_u.cmd_q, '{8'h85, 8'h11, 8'h81, 8'h10});
		run(OP_TP_ERASE, 12'h0, 19'h00011, 19'h00022, 0, 1'b0);
		chkq("tp erase", dev_u.cmd_q, '{8'h60, 8'h60, 8'hd0});
		run(4'hf, 12'h0, 19'h0, 19'h0, 0, 1'b0);
		chk("undefined op", 0, dev_u.cmd_q.size());
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		#2;
		rst_n_i = 1'b1;
		t_page_read();
		t_cache();
		t_col();
		t_multi();
		end_sim();
	end
endmodule

//--- rtl/nand_host_ctrl.sv
// nand flash host controller: command sequencer and read data path
//
// How it works
// [RQ1] two-plane read sends 00h+addr, 00h+addr, then 30h or 35h
// [RQ2] plane select sends 06h, five address cycles, then E0h
// [RQ3] two-plane program sends 80h,11h,81h/80h, then 15h or 10h; bit 31 of c is always 0, so 10h is always sent
// [RQ4] two-plane copy-back program sends 85h,11h,81h/85h, then 10h
// [RQ5] two-plane erase sends 60h,60h,D0h or 60h,D1h,60h,D0h
// [RQ6] user keeps column changes inside the loaded page
// [RQ7] only defined command codes are ever sent
// [RQ8] user keeps copy-back source and target in one plane
// [RQ9] device starts with 00h latched; we still send 00h, harmless
// [RQ10] page read is 00h, five address cycles, 30h
// [RQ11] wait for ready high before read strobes
// [RQ12] after status poll, 00h is resent before data reads
// [RQ13] data bytes read one per strobe in sequence
// [RQ14] cache read uses 31h alone or 00h+five addresses+31h
// [RQ15] after cache request wait busy; data starts at column 0
// [RQ16] column change is 05h, two column cycles, E0h
// [RQ17] continuing cache requests are waited on as busy periods
// [RQ18] 3Fh ends cache read, waits on busy
// [RQ19] sequential cache read is a lone 31h
// [RQ20] status byte is returned so bits 6 and 5 can be read
// [RQ21] random cache read sends zero column bytes
// [RQ22] command bytes go out with cle high, latched on write rising edge
// [RQ23] address bytes go out with ale high, latched on write rising edge
// [RQ24] two column bytes, three row bytes, unused bits driven low
// [RQ25] one read strobe per byte, device advances the column
// [RQ26] new read-path commands wait for ready
`timescale 1ns/1ps
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int COL_BITS = 12,
	parameter int ROW_BITS = 19,
	parameter bit ONFI     = 1'b0
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                op_valid_i,
	input  wire logic [3:0]          op_i,
	input  wire logic [COL_BITS-1:0] col_i,
	input  wire logic [ROW_BITS-1:0] row_i,
	input  wire logic [ROW_BITS-1:0] row2_i,
	input  wire logic [15:0]         count_i,
	output logic                     op_ready_o,
	output logic                     done_o,
	output logic [7:0]               rd_data_o,
	output logic                     rd_valid_o,
	input  wire logic                rd_ready_i,
	output logic                     ce_n_o,
	output logic                     cle_o,
	output logic                     ale_o,
	output logic                     we_n_o,
	output logic                     read_strobe_low_o,
	output logic [7:0]               io_o,
	output logic                     io_oe_o,
	input  wire logic [7:0]          io_i,
	input  wire logic                ready_busy_output_i
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_SETUP = 3'b001,
		S_WEHI  = 3'b010,
		S_WAIT  = 3'b011,
		S_RELO  = 3'b100,
		S_REHI  = 3'b101,
		S_DONE  = 3'b110
	} state_e;
	typedef enum logic [1:0] {
		K_CMD  = 2'b00,
		K_ADDR = 2'b01,
		K_END  = 2'b10
	} kind_e;
	typedef struct packed {
		state_e      st;
		logic [3:0]  op;
		logic [3:0]  step;
		logic [7:0]  tmr;
		logic [15:0] left;
		logic [COL_BITS-1:0] col;
		logic [ROW_BITS-1:0] row;
		logic [ROW_BITS-1:0] row2;
		logic        busy_seen;
		logic        ce_n;
		logic        cle;
		logic        ale;
		logic        we_n;
		logic        re_n;
		logic [7:0]  io;
		logic        oe;
		logic        ready;
		logic        done;
		logic [7:0]  bdata;
		logic        bvalid;
	} ctl_s;
	ctl_s r_reg;
	ctl_s r_next;
	logic       buf_in_ready;
	logic [1:0] sk;
	logic [7:0] sb;
	logic [31:0] row_w;
	logic [31:0] row2_w;

	initial begin
		if (COL_BITS > 16 || ROW_BITS > 24 || COL_BITS < 1 || ROW_BITS < 1)
			$error("address widths exceed five address cycles");
	end

	assign row_w  = 32'(r_reg.row);
	assign row2_w = 32'(r_reg.row2);

	// address byte n of a five-cycle address, unused high bits low
	function automatic logic [7:0] addr_byte(input logic [31:0] c, input logic [31:0] r,
		input int n);
		logic [7:0] b;
		b = 8'h00;
		case (n)
			0: b = c[7:0];
			1: b = c[15:8];
			2: b = r[7:0];
			3: b = r[15:8];
			default: b = r[23:16];
		endcase
		return b;
	endfunction

	// step table: kind and byte of step s of operation o
	function automatic logic [9:0] step_of(input logic [3:0] o, input logic [3:0] s,
		input logic [31:0] c, input logic [31:0] r, input logic [31:0] r2);
		logic [1:0] k;
		logic [7:0] v;
		k = K_END;
		v = 8'h00;
		case (o)
			OP_PAGE_READ, OP_CACHE_RAND: begin
				if (s == 4'h0) begin
					k = K_CMD; v = CMD_READ_SETUP; // RQ10 RQ9
				end else if (s <= 4'h5) begin
					k = K_ADDR; // RQ24
					v = (o == OP_CACHE_RAND && s <= 4'h2) ? 8'h00 // RQ21
						: addr_byte(c, r, int'(s) - 1);
				end else if (s == 4'h6) begin
					k = K_CMD; // RQ14
					v = (o == OP_CACHE_RAND) ? CMD_CACHE_NEXT : CMD_READ_GO;
				end
			end
			OP_CACHE_SEQ: if (s == 4'h0) begin
				k = K_CMD; v = CMD_CACHE_NEXT; // RQ19
			end
			OP_CACHE_LAST: if (s == 4'h0) begin
				k = K_CMD; v = CMD_CACHE_LAST; // RQ18
			end
			OP_COL_CHANGE: begin
				if (s == 4'h0) begin
					k = K_CMD; v = CMD_COL_SETUP; // RQ16
				end else if (s <= 4'h2) begin
					k = K_ADDR; v = addr_byte(c, r, int'(s) - 1); // RQ6
				end else if (s == 4'h3) begin
					k = K_CMD; v = CMD_COL_GO;
				end
			end
			OP_PLANE_SELECT: begin
				if (s == 4'h0) begin
					k = K_CMD; v = CMD_PLANE_SETUP; // RQ2
				end else if (s <= 4'h5) begin
					k = K_ADDR; v = addr_byte(c, r, int'(s) - 1);
				end else if (s == 4'h6) begin
					k = K_CMD; v = CMD_COL_GO;
				end
			end
			OP_TP_READ, OP_TP_CPB_READ: begin
				if (s == 4'h0 || s == 4'h6) begin
					k = K_CMD; v = CMD_READ_SETUP; // RQ1
				end else if (s <= 4'h5) begin
					k = K_ADDR; v = addr_byte(c, r, int'(s) - 1);
				end else if (s <= 4'hb) begin
					k = K_ADDR; v = addr_byte(c, r2, int'(s) - 7);
				end else if (s == 4'hc) begin
					k = K_CMD;
					v = (o == OP_TP_READ) ? CMD_READ_GO : CMD_CPB_READ_GO;
				end
			end
			OP_TP_PROG, OP_TP_CPB_PROG: begin
				if (s == 4'h0) begin
					k = K_CMD; // RQ3 RQ4
					v = (o == OP_TP_PROG) ? CMD_PROG_SETUP : CMD_CPB_PROG;
				end else if (s <= 4'h5) begin
					k = K_ADDR; v = addr_byte(c, r, int'(s) - 1);
				end else if (s == 4'h6) begin
					k = K_CMD; v = CMD_PLANE_NEXT;
				end else if (s == 4'h7) begin
					k = K_CMD;
					v = !ONFI ? CMD_PROG_PLANE2T
						: ((o == OP_TP_PROG) ? CMD_PROG_SETUP : CMD_CPB_PROG);
				end else if (s <= 4'hc) begin
					k = K_ADDR; v = addr_byte(c, r2, int'(s) - 8); // RQ8
				end else if (s == 4'hd) begin
					k = K_CMD;
					v = (o == OP_TP_PROG && c[31]) ? CMD_CACHE_PROG : CMD_PROG_GO;
				end
			end
			OP_TP_ERASE: begin
				// RQ5 block address only: three row cycles per 60h
				if (s == 4'h0) begin
					k = K_CMD; v = CMD_ERASE_SETUP;
				end else if (s <= 4'h3) begin
					k = K_ADDR; v = addr_byte(c, r, int'(s) + 1);
				end else if (ONFI && s == 4'h4) begin
					k = K_CMD; v = CMD_ERASE_PLANE;
				end else if (s == (ONFI ? 4'h5 : 4'h4)) begin
					k = K_CMD; v = CMD_ERASE_SETUP;
				end else if (s >= (ONFI ? 4'h6 : 4'h5) && s <= (ONFI ? 4'h8 : 4'h7)) begin
					k = K_ADDR; v = addr_byte(c, r2, int'(s) - (ONFI ? 4 : 3));
				end else if (s == (ONFI ? 4'h9 : 4'h8)) begin
					k = K_CMD; v = CMD_ERASE_GO;
				end
			end
			OP_STATUS: if (s == 4'h0) begin
				k = K_CMD; v = CMD_STATUS; // RQ20
			end
			OP_READ_DATA: if (s == 4'h0) begin
				k = K_CMD; v = CMD_READ_SETUP; // RQ12
			end
			default: k = K_END; // RQ7
		endcase
		return {k, v};
	endfunction

	assign {sk, sb} = step_of(r_reg.op, r_reg.step,
		{ONFI ? 1'b0 : r_reg.col[0] & 1'b0, 31'(r_reg.col)}, row_w, row2_w);

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		r_next.bvalid = 1'b0;
		case (r_reg.st)
			S_IDLE: begin
				r_next.ce_n = 1'b1;
				if (op_valid_i && r_reg.ready) begin
					r_next.op    = op_i;
					r_next.col   = (op_i == OP_CACHE_SEQ || op_i == OP_CACHE_LAST) ? '0 : col_i;
					r_next.row   = row_i;
					r_next.row2  = row2_i;
					r_next.left  = count_i;
					r_next.step  = 4'h0;
					r_next.ready = 1'b0;
					r_next.ce_n  = 1'b0;
					r_next.st    = S_SETUP;
				end
			end
			S_SETUP: begin
				if (sk == K_END) begin
					r_next.cle = 1'b0;
					r_next.ale = 1'b0;
					r_next.oe  = 1'b0;
					r_next.tmr = 8'h00;
					r_next.busy_seen = 1'b0;
					r_next.st  = S_WAIT;
				end else begin
					r_next.cle  = (sk == K_CMD); // RQ22
					r_next.ale  = (sk == K_ADDR); // RQ23
					r_next.io   = sb;
					r_next.oe   = 1'b1;
					r_next.we_n = 1'b0;
					r_next.st   = S_WEHI;
				end
			end
			S_WEHI: begin
				r_next.we_n = 1'b1; // RQ22 RQ23
				r_next.step = r_reg.step + 4'h1;
				r_next.st   = S_SETUP;
			end
			S_WAIT: begin
				// RQ11 RQ15 RQ17 RQ26 wait at least STROBE_CYC + 2 cycles, then for ready high
				r_next.tmr = r_reg.tmr + 8'h01;
				if (!ready_busy_output_i)
					r_next.busy_seen = 1'b1;
				if (r_reg.tmr >= 8'(STROBE_CYC + 2) && ready_busy_output_i) begin
					r_next.st = (r_reg.left != 16'h0000 &&
						(r_reg.op == OP_STATUS || r_reg.op == OP_READ_DATA ||
						 r_reg.op == OP_CACHE_SEQ || r_reg.op == OP_CACHE_RAND ||
						 r_reg.op == OP_CACHE_LAST || r_reg.op == OP_PAGE_READ ||
						 r_reg.op == OP_COL_CHANGE || r_reg.op == OP_PLANE_SELECT))
						? S_RELO : S_DONE;
				end
			end
			S_RELO: begin
				// a byte still on its way to the buffer holds its place
				if (buf_in_ready && !r_reg.bvalid) begin
					r_next.re_n = 1'b0; // RQ25
					r_next.st   = S_REHI;
				end
			end
			S_REHI: begin
				r_next.re_n   = 1'b1; // RQ13
				r_next.bdata  = io_i;
				r_next.bvalid = 1'b1;
				r_next.left   = r_reg.left - 16'h0001;
				r_next.st     = (r_reg.left == 16'h0001) ? S_DONE : S_RELO;
			end
			S_DONE: begin
				r_next.done  = 1'b1;
				r_next.ready = 1'b1;
				r_next.ce_n  = 1'b1;
				r_next.st    = S_IDLE;
			end
			default: r_next.st = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r_reg       <= '0;
			r_reg.st    <= S_IDLE;
			r_reg.ce_n  <= 1'b1;
			r_reg.we_n  <= 1'b1;
			r_reg.re_n  <= 1'b1;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	nand_word_buf #(
		.WIDTH(8)
	) u_buf (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.in_data_i  (r_reg.bdata),
		.in_valid_i (r_reg.bvalid),
		.in_ready_o (buf_in_ready),
		.out_data_o (rd_data_o),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i)
	);

	assign op_ready_o        = r_reg.ready;
	assign done_o            = r_reg.done;
	assign ce_n_o            = r_reg.ce_n;
	assign cle_o             = r_reg.cle;
	assign ale_o             = r_reg.ale;
	assign we_n_o            = r_reg.we_n;
	assign read_strobe_low_o = r_reg.re_n;
	assign io_o              = r_reg.io;
	assign io_oe_o           = r_reg.oe;
endmodule

//--- rtl/nand_host_pkg.sv
// constants for the nand host controller
package nand_host_pkg;
	localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
	localparam logic [7:0] CMD_READ_GO      = 8'h30;
	localparam logic [7:0] CMD_CPB_READ_GO  = 8'h35;
	localparam logic [7:0] CMD_CACHE_NEXT   = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST   = 8'h3f;
	localparam logic [7:0] CMD_COL_SETUP    = 8'h05;
	localparam logic [7:0] CMD_PLANE_SETUP  = 8'h06;
	localparam logic [7:0] CMD_COL_GO       = 8'he0;
	localparam logic [7:0] CMD_STATUS       = 8'h70;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
	localparam logic [7:0] CMD_PROG_PLANE2T = 8'h81;
	localparam logic [7:0] CMD_CPB_PROG     = 8'h85;
	localparam logic [7:0] CMD_PLANE_NEXT   = 8'h11;
	localparam logic [7:0] CMD_PROG_GO      = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG   = 8'h15;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
	localparam logic [7:0] CMD_ERASE_PLANE  = 8'hd1;
	localparam logic [7:0] CMD_ERASE_GO     = 8'hd0;
	// operation codes on op_i
	localparam logic [3:0] OP_PAGE_READ     = 4'h0;
	localparam logic [3:0] OP_CACHE_SEQ     = 4'h1;
	localparam logic [3:0] OP_CACHE_RAND    = 4'h2;
	localparam logic [3:0] OP_CACHE_LAST    = 4'h3;
	localparam logic [3:0] OP_COL_CHANGE    = 4'h4;
	localparam logic [3:0] OP_PLANE_SELECT  = 4'h5;
	localparam logic [3:0] OP_TP_READ       = 4'h6;
	localparam logic [3:0] OP_TP_CPB_READ   = 4'h7;
	localparam logic [3:0] OP_TP_PROG       = 4'h8;
	localparam logic [3:0] OP_TP_CPB_PROG   = 4'h9;
	localparam logic [3:0] OP_TP_ERASE      = 4'ha;
	localparam logic [3:0] OP_STATUS        = 4'hb;
	localparam logic [3:0] OP_READ_DATA     = 4'hc;
	// status bits
	localparam int STAT_RDY_BIT  = 6;
	localparam int STAT_CRDY_BIT = 5;
	// pin timing, 25 MHz clock
	localparam int CLK_MHZ       = 25;
	localparam int T_STROBE_NS   = 40;
	localparam int STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int MAX_STEPS     = 16;
	localparam logic [3:0] STEP_LAST = 4'hf;
endpackage

//--- rtl/nand_word_buf.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module nand_word_buf #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic                  rd;
		logic                  wr;
		logic [1:0]            cnt;
	} buf_s;
	buf_s st_reg;
	buf_s st_next;
	logic push;
	logic pop;
	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end
	assign push = in_valid_i && (st_reg.cnt != 2'h2);
	assign pop  = out_ready_i && (st_reg.cnt != 2'h0);
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = ~st_reg.wr;
		end
		if (pop) begin
			st_next.rd = ~st_reg.rd;
		end
		st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign in_ready_o  = st_reg.cnt != 2'h2;
	assign out_valid_o = st_reg.cnt != 2'h0;
	assign out_data_o  = st_reg.mem[st_reg.rd];
endmodule
